// [rtl/tcc_pkg.sv]
// Purpose: Shared constants, carriers and states of the counter/timer unit.
// Assumes: Host writes arrive as one-cycle requests synchronous to core_clk.
// Notes:   Control word fields are carried as a packed struct, D7 first.
package tcc_pkg;

   // Unit geometry
   localparam int NUM_CHAN = 4;             // Channels in the unit
   localparam int CHAN_W   = 2;             // Channel number width

   // Prescaler terminal counts (divide by 16 or by 256)
   localparam logic [7:0] PSC_LAST_LO = 8'h0F;
   localparam logic [7:0] PSC_LAST_HI = 8'hFF;
   localparam logic [7:0] PSC_RESET   = 8'h00;

   // Triggered start timing, in system clocks
   localparam logic [1:0] TRIG_GUARD_CYC = 2'h2; // Least gap from load to trigger
   localparam logic [1:0] TRIG_START_CYC = 2'h2; // Trigger edge to prescaler start
   localparam logic [1:0] ARM_LOAD       = 2'(TRIG_START_CYC - 2'h2);

   // Values after reset
   localparam logic [7:0] CTRL_RESET = 8'h00;    // Interrupts off, nothing pending
   localparam logic [7:0] TC_RESET   = 8'h00;
   localparam logic [8:0] CNT_RESET  = 9'h000;
   localparam logic [4:0] VEC_RESET  = 5'h00;    // Host part of the vector
   localparam logic [8:0] CNT_ONE    = 9'h001;   // Count value that ends a period
   localparam logic [8:0] TC_FULL    = 9'h100;   // All-zero constant means 256

   // Vector layout: host bits 7..3, channel code 2..1, bit 0 low
   localparam int VEC_CODE_LSB = 1;

   // Channel control word as written by the host
   typedef struct packed {
      logic intEn;        // D7: request interrupt at zero count
      logic counterMode;  // D6: count pin edges instead of prescaled clock
      logic pscHigh;      // D5: divide by 256 instead of 16
      logic risingEdge;   // D4: active pin edge is rising
      logic trigStart;    // D3: timer waits for a pin edge
      logic tcFollows;    // D2: next write is a time constant
      logic stop;         // D1: halt the down-counter
      logic ctlFlag;      // D0: set for control words, clear for vectors
   } tcc_ctrl_t;

   // One host write to the unit
   typedef struct packed {
      logic                valid; // One-cycle write strobe
      logic [CHAN_W-1:0]   chan;  // Addressed channel
      logic [7:0]          data;  // Byte written
   } tcc_wr_t;

   // Channel operating states
   typedef enum logic [2:0] {
      ST_IDLE,       // After reset, never programmed
      ST_WAIT_TC,    // Stopped, waiting for a time constant
      ST_WAIT_TRIG,  // Loaded, waiting for the start edge
      ST_ARM,        // Start edge seen, prescaler about to run
      ST_RUN,        // Down-counter active
      ST_HALT        // Stopped, waiting for a control word
   } tcc_state_t;

   // Time constant to period length, zero standing for 256
   function automatic logic [8:0] tcc_expand(logic [7:0] v);
      tcc_expand = (v == 8'h00) ? TC_FULL : {1'b0, v};
   endfunction

endpackage

// [rtl/tcc_counter_timer_unit.sv]
// Purpose: Four-channel counter/timer unit with control, constant and vector writes.
// Assumes: Pin inputs and host writes are synchronous to core_clk.
// Notes:   Zero count pulses and interrupt requests are registered outputs.
//
// Contract
// RL1: D6 clear: prescaled system clock decrements counter
// RL2: D6 set: pin edges decrement, prescaler bypassed
// RL3: D5 clear divides system clock by 16
// RL4: D4 picks pin edge, 0 falling, 1 rising
// RL5: D3 clear: timer starts itself after loading
// RL6: D3 set: timer starts on later pin edge
// RL7: Prescaler starts second clock after trigger edge
// RL8: Trigger before load acts as D3 clear
// RL9: D2 set: next channel write is constant
// RL10: First word after reset has D2 set
// RL11: Constant written while counting loads at zero
// RL12: D1 set stops counter, keeps other settings
// RL13: D2 and D1 set: wait for constant
// RL14: D2 clear, D1 set: wait for control word
// RL15: Constant zero means 256, range 1-256
// RL16: Channel 0 write with D0 clear is vector
// RL17: Vector bits 7..3 from host, 2..1 auto
// RL18: Channel code binary, channel 0 highest priority
// RL19: Control words always have D0 set
// RL20: D7 set requests interrupt at every zero
// RL21: Enabling while running waits for next zero
// RL22: Zero count reloads and keeps counting
// RL23: After reset idle, interrupts off, until programmed
module tcc_counter_timer_unit #(
   parameter int NUM_CHAN = tcc_pkg::NUM_CHAN
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire tcc_pkg::tcc_wr_t      hostWr,
   input  wire logic [NUM_CHAN-1:0]   clockTriggerIn,
   input  wire logic                  intAck,
   output logic [NUM_CHAN-1:0]        zeroCount,
   output logic [NUM_CHAN-1:0]        chanRunning,
   output logic                       intReq,
   output logic [7:0]                 intVector
);

   // Reset synchroniser: asserts at once, releases after two edges
   logic rstMeta_q;
   logic rstSync_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // Per-channel views collected for the shared logic
   logic [NUM_CHAN-1:0] expTcW;      // Channel expects a time constant
   logic [NUM_CHAN-1:0] pendW;       // Channel interrupt pending
   logic [NUM_CHAN-1:0] ackClr;      // One-hot clear of the served channel
   logic [NUM_CHAN-1:0] zeroW;       // Registered zero pulses
   logic [NUM_CHAN-1:0] runW;        // Registered running flags

   // Vector write: channel 0, no constant due, D0 clear
   logic       vecWr;
   logic [4:0] vecHi_q;              // Host-written vector bits 7..3
   assign vecWr = hostWr.valid && (hostWr.chan == '0) && !expTcW[0]
                  && !hostWr.data[0];                                    // RL16

   // Priority encoder: lowest numbered pending channel wins
   logic [1:0] topCode;
   logic       anyPend;
   always_comb begin
      topCode = 2'h0;
      ackClr  = '0;
      for (int k = NUM_CHAN - 1; k >= 0; k--) begin
         if (pendW[k]) begin
            topCode = 2'(k);                                             // RL18
         end
      end
      if (intAck && (pendW != '0)) begin
         ackClr[topCode] = 1'b1;
      end
   end
   assign anyPend = |pendW;

   // Shared vector register and interrupt outputs
   always_ff @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         vecHi_q   <= tcc_pkg::VEC_RESET;
         intReq    <= 1'b0;
         intVector <= 8'h00;
      end else begin
         if (vecWr) begin
            vecHi_q <= hostWr.data[7:3];                                 // RL17
         end
         intReq    <= anyPend;
         intVector <= {vecHi_q, topCode, 1'b0};                          // RL17
      end
   end

   // One copy of the channel logic per channel
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan

      // Channel registers
      tcc_pkg::tcc_ctrl_t  ctrl_q;           // Current control word
      logic [7:0]          tc_q;             // Time constant register
      logic [8:0]          cnt_q;            // Down-counter, 1 to 256
      logic [8:0]          cnt_d;
      logic [7:0]          psc_q;            // Prescaler phase
      logic [7:0]          psc_d;
      logic [1:0]          guard_q;          // Cycles before a trigger counts
      logic [1:0]          guard_d;
      logic [1:0]          arm_q;            // Cycles left before running
      logic [1:0]          arm_d;
      logic                expTc_q;          // Next write is a constant
      logic                trigSeen_q;       // Edge arrived before loading
      logic                trigSeen_d;
      logic                trgPrev_q;        // Pin level one cycle ago
      logic                pend_q;           // Interrupt request pending
      logic                zero_q;           // Zero count pulse
      logic                run_q;            // Running flag
      tcc_pkg::tcc_state_t state_q;
      tcc_pkg::tcc_state_t state_d;

      // Write decode for this channel
      logic               wrHit;
      logic               tcWr;
      logic               ctlWr;
      tcc_pkg::tcc_ctrl_t newCw;
      localparam logic [tcc_pkg::CHAN_W-1:0] CHAN_SEL = tcc_pkg::CHAN_W'(i);
      assign wrHit = hostWr.valid && (hostWr.chan == CHAN_SEL);
      assign tcWr  = wrHit && expTc_q;                                   // RL9
      assign ctlWr = wrHit && !expTc_q && hostWr.data[0];                // RL19
      assign newCw = tcc_pkg::tcc_ctrl_t'(hostWr.data);

      // Pin edge detection on the selected polarity
      logic rise;
      logic fall;
      logic actEdge;
      assign rise    = clockTriggerIn[i] && !trgPrev_q;
      assign fall    = !clockTriggerIn[i] && trgPrev_q;
      assign actEdge = ctrl_q.risingEdge ? rise : fall;                  // RL4

      // Decrement tick: pin edge or prescaler wrap
      logic [7:0] pscLast;
      logic       pscWrap;
      logic       tick;
      logic       zeroHit;
      assign pscLast = ctrl_q.pscHigh ? tcc_pkg::PSC_LAST_HI
                                      : tcc_pkg::PSC_LAST_LO;            // RL3
      assign pscWrap = (psc_q == pscLast);                               // RL1
      assign tick    = (state_q == tcc_pkg::ST_RUN)
                       && (ctrl_q.counterMode ? actEdge : pscWrap);      // RL2
      assign zeroHit = tick && (cnt_q == tcc_pkg::CNT_ONE);

      // Start decision once a constant lands in a stopped channel
      logic                loadStart;
      tcc_pkg::tcc_state_t startState;
      assign loadStart  = tcWr && (state_q != tcc_pkg::ST_RUN)
                          && (state_q != tcc_pkg::ST_WAIT_TRIG)
                          && (state_q != tcc_pkg::ST_ARM);
      assign startState = (ctrl_q.counterMode || !ctrl_q.trigStart
                           || trigSeen_q) ? tcc_pkg::ST_RUN              // RL5 RL8
                                          : tcc_pkg::ST_WAIT_TRIG;       // RL6

      // Trigger goes straight to running when no arming cycle is wanted
      localparam bit ARM_ZERO = (tcc_pkg::TRIG_START_CYC <= 2'h1);

      // Next state, counter and prescaler
      always_comb begin
         state_d    = state_q;
         cnt_d      = cnt_q;
         psc_d      = psc_q;
         guard_d    = guard_q;
         arm_d      = arm_q;
         trigSeen_d = trigSeen_q;
         unique case (state_q)
            tcc_pkg::ST_IDLE: begin
               trigSeen_d = 1'b0;
            end
            tcc_pkg::ST_WAIT_TC: begin
               // Remember an early edge so loading starts at once
               if (actEdge && ctrl_q.trigStart) begin
                  trigSeen_d = 1'b1;                                     // RL8
               end
            end
            tcc_pkg::ST_WAIT_TRIG: begin
               // Edges too close to the load are ignored
               if (guard_q != 2'h0) begin
                  guard_d = guard_q - 2'h1;                              // RL6
               end else if (actEdge) begin
                  state_d = (ARM_ZERO) ? tcc_pkg::ST_RUN : tcc_pkg::ST_ARM;
                  arm_d   = tcc_pkg::ARM_LOAD;                           // RL7
                  psc_d   = tcc_pkg::PSC_RESET;
               end
            end
            tcc_pkg::ST_ARM: begin
               if (arm_q == 2'h0) begin
                  state_d = tcc_pkg::ST_RUN;                             // RL7
               end else begin
                  arm_d = arm_q - 2'h1;
               end
            end
            tcc_pkg::ST_RUN: begin
               // Prescaler free-runs only in timer mode
               if (!ctrl_q.counterMode) begin
                  psc_d = pscWrap ? tcc_pkg::PSC_RESET : psc_q + 8'h01;  // RL1
               end
               if (zeroHit) begin
                  cnt_d = tcc_pkg::tcc_expand(tc_q);                     // RL11 RL22
               end else if (tick) begin
                  cnt_d = cnt_q - 9'h001;
               end
            end
            tcc_pkg::ST_HALT: begin
               trigSeen_d = 1'b0;
            end
         endcase

         // A control word overrides the running sequence
         if (ctlWr) begin
            if (newCw.stop) begin
               state_d = newCw.tcFollows ? tcc_pkg::ST_WAIT_TC           // RL13
                                         : tcc_pkg::ST_HALT;             // RL14 RL12
               trigSeen_d = 1'b0;
            end else if (newCw.tcFollows && (state_q == tcc_pkg::ST_IDLE
                         || state_q == tcc_pkg::ST_HALT)) begin
               state_d    = tcc_pkg::ST_WAIT_TC;                         // RL23
               trigSeen_d = 1'b0;
            end else if (state_q == tcc_pkg::ST_HALT) begin
               state_d = tcc_pkg::ST_RUN;                                // RL12
            end
         end

         // Constant into a stopped channel loads and starts it
         if (loadStart) begin
            cnt_d      = tcc_pkg::tcc_expand(hostWr.data);               // RL15
            psc_d      = tcc_pkg::PSC_RESET;
            guard_d    = tcc_pkg::TRIG_GUARD_CYC - 2'h1;
            state_d    = startState;                                     // RL13
            trigSeen_d = 1'b0;
         end
      end

      // Channel state registers
      always_ff @(posedge core_clk or negedge rstSync_q) begin
         if (!rstSync_q) begin
            state_q    <= tcc_pkg::ST_IDLE;
            cnt_q      <= tcc_pkg::CNT_RESET;
            psc_q      <= tcc_pkg::PSC_RESET;
            guard_q    <= 2'h0;
            arm_q      <= 2'h0;
            trigSeen_q <= 1'b0;
            trgPrev_q  <= 1'b0;
         end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            psc_q      <= psc_d;
            guard_q    <= guard_d;
            arm_q      <= arm_d;
            trigSeen_q <= trigSeen_d;
            trgPrev_q  <= clockTriggerIn[i];
         end
      end

      // Programming registers: control word and time constant
      always_ff @(posedge core_clk or negedge rstSync_q) begin
         if (!rstSync_q) begin
            ctrl_q  <= tcc_pkg::tcc_ctrl_t'(tcc_pkg::CTRL_RESET);       // RL23
            tc_q    <= tcc_pkg::TC_RESET;
            expTc_q <= 1'b0;
         end else if (ctlWr) begin
            ctrl_q  <= newCw;
            expTc_q <= newCw.tcFollows;                                  // RL9
         end else if (tcWr) begin
            tc_q    <= hostWr.data;                                      // RL11
            expTc_q <= 1'b0;
         end
      end

      // Zero pulse, running flag and interrupt request
      // A new zero beats an acknowledge in the same cycle
      always_ff @(posedge core_clk or negedge rstSync_q) begin
         if (!rstSync_q) begin
            zero_q <= 1'b0;
            run_q  <= 1'b0;
            pend_q <= 1'b0;
         end else begin
            zero_q <= zeroHit;
            run_q  <= (state_d == tcc_pkg::ST_RUN);
            if (zeroHit && ctrl_q.intEn) begin
               pend_q <= 1'b1;                                           // RL20 RL21
            end else if (ackClr[i]) begin
               pend_q <= 1'b0;
            end
         end
      end

      assign expTcW[i] = expTc_q;
      assign pendW[i]  = pend_q;
      assign zeroW[i]  = zero_q;
      assign runW[i]   = run_q;
   end

   assign zeroCount   = zeroW;
   assign chanRunning = runW;

endmodule

// [test/tcc_host_model.sv]
// Purpose: Host processor model issuing one-cycle writes to the unit.
// Assumes: Writes are taken on the rising edge while the strobe is high.
// Notes:   Released bus shows inverted data so stale values never match.
module tcc_host_model (
   input  wire logic       core_clk,
   output tcc_pkg::tcc_wr_t hostWr
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idle at time zero
   initial hostWr = '{valid: 1'b0, chan: 2'h0, data: 8'h00};

   // One write: strobe for exactly one cycle, then release the bus
   task automatic put(input logic [1:0] ch, input logic [7:0] d);
      @(negedge core_clk);
      hostWr = '{valid: 1'b1, chan: ch, data: d};
      @(negedge core_clk);
      hostWr = '{valid: 1'b0, chan: ~ch, data: ~d};
   endtask
endmodule

// [test/tcc_checker_properties.sv]
// Purpose: Port-level checker for the counter/timer unit.
// Assumes: Host writes follow the one-cycle strobe protocol.
// Notes:   Helper logic mirrors which write is a time constant, any write since reset, the host vector bits and the last stop channel.
module tcc_checker #(
   parameter int NUM_CHAN = 4
) (
   input wire logic                core_clk,
   input wire logic                rst_n,
   input wire tcc_pkg::tcc_wr_t    hostWr,
   input wire logic [NUM_CHAN-1:0] clockTriggerIn,
   input wire logic                intAck,
   input wire logic [NUM_CHAN-1:0] zeroCount,
   input wire logic [NUM_CHAN-1:0] chanRunning,
   input wire logic                intReq,
   input wire logic [7:0]          intVector
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [NUM_CHAN-1:0] tcPend_q;  // Channel expects a constant next
   logic [NUM_CHAN-1:0] tcPend_d;
   logic                seenWr_q;  // Any write since reset
   logic [4:0]          vecHost_q; // Last host vector bits
   logic [1:0]          stopCh_q;  // Channel of last stop word
   logic                pendNow;
   logic                isCtl;
   logic                isVec;
   logic                isStop;

   // Write decode, constant first, then control word, then vector
   assign pendNow = tcPend_q[hostWr.chan];
   assign isCtl   = hostWr.valid && !pendNow && hostWr.data[0];
   assign isVec   = hostWr.valid && !pendNow && !hostWr.data[0] && (hostWr.chan == 2'h0);
   assign isStop  = isCtl && hostWr.data[1] && !hostWr.data[2];

   // Pending flag: set by D2, cleared by the constant itself
   always_comb begin
      tcPend_d = tcPend_q;
      if (hostWr.valid) begin
         tcPend_d[hostWr.chan] = isCtl && hostWr.data[2];
      end
   end

   // Helper registers, cleared with the unit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tcPend_q  <= '0;
         seenWr_q  <= 1'b0;
         vecHost_q <= 5'h00;
         stopCh_q  <= 2'h0;
      end else begin
         tcPend_q <= tcPend_d;
         seenWr_q <= seenWr_q | hostWr.valid;
         if (isVec) vecHost_q <= hostWr.data[7:3];
         if (isStop) stopCh_q <= hostWr.chan;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence stopWord;
      isStop;
   endsequence
   sequence vecWord;
      isVec;
   endsequence

   chk_vec_bit_zero: assert property (intVector[0] == 1'b0)
      else $error("vector bit 0 not low");
   chk_idle_after_reset: assert property (!seenWr_q |-> chanRunning == '0 && !intReq)
      else $error("activity before programming");
   chk_req_after_zero: assert property ($rose(intReq) |-> $past(|zeroCount))
      else $error("request without zero count");
   chk_req_drop_ack: assert property ($fell(intReq) |-> $past(intAck, 2))
      else $error("request dropped without acknowledge");
   chk_zero_single: assert property ((zeroCount & $past(zeroCount)) == '0)
      else $error("zero pulse longer than one cycle");
   chk_zero_needs_run: assert property ((zeroCount & ~$past(chanRunning)) == '0)
      else $error("zero count on a stopped channel");
   chk_vec_host_load: assert property (vecWord |-> ##2 intVector[7:3] == vecHost_q)
      else $error("vector host bits not loaded");
   chk_stop_halts: assert property (stopWord |-> ##2 !chanRunning[stopCh_q])
      else $error("stop word did not halt channel");
endmodule

bind tcc_counter_timer_unit tcc_checker #(.NUM_CHAN(NUM_CHAN)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .hostWr(hostWr), .clockTriggerIn(clockTriggerIn),
   .intAck(intAck), .zeroCount(zeroCount), .chanRunning(chanRunning), .intReq(intReq),
   .intVector(intVector));

// [test/tb_top.sv]
// Purpose: Self-checking bench for the four-channel counter/timer unit.
// Assumes: Inputs change on the falling edge; zero pulses timed at rising edges.
// Notes:   Periods are measured between successive zero pulses of a channel.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic             core_clk = 1'b0;
   logic             rst_n;
   logic [3:0]       pin;          // Clock/trigger inputs
   logic             intAck;
   tcc_pkg::tcc_wr_t hostWr;
   logic [3:0]       zeroCount;
   logic [3:0]       chanRunning;
   logic             intReq;
   logic [7:0]       intVector;
   int               num_errors = 0;
   int               n_compared = 0;
   int               cyc = 0;
   int               zc[4] = '{default: 0};    // Zero pulses seen
   int               lastZ[4] = '{default: 0}; // Cycle of latest zero
   int               prevZ[4] = '{default: 0}; // Cycle of the one before
   int               t0;

   always #4 core_clk = ~core_clk;

   tcc_host_model u_host (.core_clk(core_clk), .hostWr(hostWr));

   tcc_counter_timer_unit #(.NUM_CHAN(4)) u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .hostWr(hostWr), .clockTriggerIn(pin),
      .intAck(intAck), .zeroCount(zeroCount), .chanRunning(chanRunning), .intReq(intReq),
      .intVector(intVector));

   task automatic final_report();
      $display("Errors %0d of %0d compares", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Bounded wait for k more zero pulses
   task automatic waitz(input int ch, input int k);
      int n0;
      n0 = zc[ch];
      for (int i = 0; i < 10000 && zc[ch] < n0 + k; i++) @(negedge core_clk);
      // A wait that runs out is a mismatch of its own
      if (zc[ch] < n0 + k) begin
         num_errors++;
         $display("[ERR] zeroWait ch%0d expected %0d seen %0d", ch, n0 + k, zc[ch]);
      end
   endtask

   task automatic ack();
      @(negedge core_clk);
      intAck = 1'b1;
      @(negedge core_clk);
      intAck = 1'b0;
   endtask

   // One active edge, each level held two clocks
   task automatic pulse(input int ch, input logic act);
      pin[ch] = ~act;
      cyc_n(2);
      pin[ch] = act;
      cyc_n(2);
   endtask

   function automatic logic [15:0] per(input int ch);
      return 16'(lastZ[ch] - prevZ[ch]);
   endfunction

   // Cycle count, hang guard and zero pulse log
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 30000) begin
         num_errors++;
         final_report();
      end else for (int i = 0; i < 4; i++) if (zeroCount[i] === 1'b1) begin
         prevZ[i] = lastZ[i];
         lastZ[i] = cyc;
         zc[i]++;
      end
   end

   initial begin
      rst_n = 1'b0;
      intAck = 1'b0;
      pin = 4'h0;
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      cyc_n(4);
      chk("running", 16'h0000, 16'(chanRunning));
      chk("intReq", 16'h0000, 16'(intReq));
      u_host.put(2'h1, 8'h01);
      cyc_n(4);
      chk("idle", 16'h0000, 16'(chanRunning));
      u_host.put(2'h0, 8'hA8);
      u_host.put(2'h0, 8'h85);
      u_host.put(2'h0, 8'h03);
      waitz(0, 2);
      chk("period16", 16'h0030, per(0));
      cyc_n(2);
      chk("vector0", 16'h00A8, 16'(intVector));
      chk("intReq", 16'h0001, 16'(intReq));
      ack();
      cyc_n(3);
      chk("intReqAck", 16'h0000, 16'(intReq));
      // New constant while counting waits for the zero
      u_host.put(2'h0, 8'h85);
      u_host.put(2'h0, 8'h05);
      waitz(0, 1);
      chk("oldTc", 16'h0030, per(0));
      waitz(0, 1);
      chk("newTc", 16'h0050, per(0));
      u_host.put(2'h0, 8'h87);
      t0 = zc[0];
      cyc_n(200);
      chk("heldTc", 16'(t0), 16'(zc[0]));
      u_host.put(2'h0, 8'h02);
      waitz(0, 2);
      chk("restart", 16'h0020, per(0));
      u_host.put(2'h0, 8'h83);
      t0 = zc[0];
      cyc_n(100);
      chk("stopped", 16'(t0), 16'(zc[0]));
      u_host.put(2'h0, 8'h81);
      waitz(0, 2);
      chk("resumed", 16'h0020, per(0));
      u_host.put(2'h0, 8'h03);
      ack();
      // Zero constant gives the longest period
      u_host.put(2'h1, 8'h85);
      u_host.put(2'h1, 8'h00);
      waitz(1, 2);
      chk("tc256", 16'h1000, per(1));
      cyc_n(2);
      chk("vector1", 16'h00AA, 16'(intVector));
      u_host.put(2'h1, 8'h03);
      // Long prescaler setting, constant one, no interrupt
      u_host.put(2'h1, 8'h25);
      u_host.put(2'h1, 8'h01);
      waitz(1, 2);
      chk("psc256", 16'h0100, per(1));
      u_host.put(2'h1, 8'h03);
      // Counter mode, falling then rising edges
      for (int e = 0; e < 2; e++) begin
         u_host.put(2'h2, (e == 1) ? 8'h55 : 8'h45);
         u_host.put(2'h2, 8'h03);
         t0 = zc[2];
         pulse(2, 1'(e));
         pulse(2, 1'(e));
         chk("cnt2", 16'(t0), 16'(zc[2]));
         pulse(2, 1'(e));
         cyc_n(2);
         chk("cnt3", 16'(t0 + 1), 16'(zc[2]));
      end
      // Trigger edge before the constant acts as self start
      u_host.put(2'h2, 8'h0F);
      pin[2] = 1'b0;
      u_host.put(2'h2, 8'h01);
      cyc_n(4);
      chk("preTrig", 16'h0001, 16'(chanRunning[2]));
      // Triggered start after the guard time
      u_host.put(2'h3, 8'h9D);
      u_host.put(2'h3, 8'h01);
      cyc_n(20);
      chk("waitTrig", 16'h0000, 16'(chanRunning[3]));
      pin[3] = 1'b1;
      t0 = cyc;
      waitz(3, 1);
      chk("trigDelay", 16'h0001, 16'(lastZ[3] - t0 >= 17 && lastZ[3] - t0 <= 21));
      cyc_n(2);
      chk("prio", 16'h00AA, 16'(intVector));
      ack();
      cyc_n(3);
      chk("prio3", 16'h00AE, 16'(intVector));
      final_report();
   end
endmodule
